// *** pbl_bist_ctrl.sv ***
`timescale 1ns/10ps
`include "pbl_cfg.svh"

module pbl_bist_ctrl (
    input  wire logic              CLK_I,
    input  wire logic              ARST_N_I,
    input  wire logic [7:0]        REG_ADDR_I,
    input  wire logic [15:0]       REG_WDATA_I,
    input  wire logic              REG_WR_I,
    input  wire logic              REG_RD_I,
    output logic [15:0]            REG_RDATA_O,
    input  wire pbl_pkg::pbl_bit_t MAC_TX_I,
    output pbl_pkg::pbl_bit_t      MAC_RX_O,
    output pbl_pkg::pbl_bit_t      LINE_TX_O,
    input  wire pbl_pkg::pbl_bit_t LINE_RX_I,
    input  wire logic              RX_OVF_I,
    input  wire logic              RX_UNF_I,
    input  wire logic              STRAP_RGMII_I,
    input  wire logic              STRAP_RMII_I,
    input  wire logic              STRAP_CLKSEL_I,
    input  wire logic              STRAP_RXDLY_I,
    input  wire logic              STRAP_TXDLY_I,
    output pbl_pkg::pbl_mode_t     MODE_O,
    output logic                   CRS_DV_O,
    output logic                   ERR_WRAP_O,
    output logic                   IRQ_O
);
    logic [1:0]           rsync_r;
    logic                 rst_n;
    pbl_pkg::pbl_st_t     r;
    pbl_pkg::pbl_st_t     n;
    pbl_pkg::pbl_bist_t   bw;
    pbl_pkg::pbl_xmii_t   xw;
    pbl_pkg::pbl_bit_t    txp;
    pbl_pkg::pbl_bit_t    src;
    pbl_pkg::pbl_irq_t    ev;
    logic                 active;
    logic                 gbit;
    logic [7:0]           const_byte;
    pbl_pkg::pbl_bit_t    ltx_mux;
    logic                 rd_bist;
    logic                 clr_cnt;
    logic                 chk_lock;
    logic                 chk_loss;
    logic                 chk_wrap;
    logic [15:0]          chk_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rsync_r <= 2'h0;
        end else begin
            rsync_r <= {rsync_r[0], 1'b1};
        end
    end
    assign rst_n = rsync_r[1];

    ////////////////////////////////////////////////////////////////////////
    // Checker
    assign rd_bist = REG_RD_I && REG_ADDR_I == `PBL_A_BIST;
    assign clr_cnt = REG_WR_I && REG_ADDR_I == `PBL_A_ERRC;

    pbl_prbs_chk u_chk (
        .clk_i   (CLK_I),
        .rst_n_i (rst_n),
        .en_i    (r.bist.pktt),
        .rx_i    (src),
        .cmode_i (r.bist.cmode),
        .clr_i   (clr_cnt),
        .lock_o  (chk_lock),
        .loss_o  (chk_loss),
        .wrap_o  (chk_wrap),
        .cnt_o   (chk_cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Generator and loopback paths
    assign active = r.gst == pbl_pkg::PBL_G_PKT || r.gst == pbl_pkg::PBL_G_GAP;
    assign const_byte = `PBL_CONST_BYTE;
    assign gbit = r.bist.pktt ? pbl_pkg::pbl_prbs_fb(r.glfsr)
                              : const_byte[r.gcnt[2:0]];

    always_comb begin
        txp = MAC_TX_I;
        if (active) begin
            txp.en = r.gst == pbl_pkg::PBL_G_PKT;
            txp.d  = gbit;
        end
    end

    always_comb begin
        src = LINE_RX_I;
        ltx_mux = txp;
        if (r.mac_lp) begin
            src = MAC_TX_I;
            ltx_mux = r.bist.lptx ? txp : '0;
        end else begin
            unique case (r.bist.lpsel)
                pbl_pkg::PBL_LP_PCS, pbl_pkg::PBL_LP_ANA: begin
                    src = txp;
                    ltx_mux = '0;
                end
                pbl_pkg::PBL_LP_REV: begin
                    ltx_mux = LINE_RX_I;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        n.bist = r.bist;
        n.xmii = r.xmii;
        n.mac_lp = r.mac_lp;
        n.ists = r.ists;
        n.ien = r.ien;
        n.gst = r.gst;
        n.gcnt = r.gcnt;
        n.glfsr = r.glfsr;
        n.ltx = ltx_mux;
        n.strap_done = 1'b1;
        n.rdata = '0;
        ev = '0;
        bw = pbl_pkg::pbl_bist_t'(REG_WDATA_I);
        xw = pbl_pkg::pbl_xmii_t'(REG_WDATA_I);

        unique case (r.gst)
            pbl_pkg::PBL_G_IDLE: begin
                n.gcnt = '0;
                n.glfsr = `PBL_PRBS_SEED;
                if (r.bist.gen) begin
                    n.gst = pbl_pkg::PBL_G_PKT;
                end
            end
            pbl_pkg::PBL_G_PKT: begin
                n.gcnt = r.gcnt + 10'h001;
                if (r.bist.pktt) begin
                    n.glfsr = {r.glfsr[13:0], gbit};
                end
                if (r.gcnt == `PBL_PKT_BITS - 10'h001) begin
                    n.gcnt = '0;
                    if (r.bist.pktt) begin
                        n.gst = pbl_pkg::PBL_G_GAP;
                    end else begin
                        n.gst = pbl_pkg::PBL_G_DONE;
                        ev.done = 1'b1;
                    end
                end
                if (!r.bist.gen) begin
                    n.gst = pbl_pkg::PBL_G_IDLE;
                end
            end
            pbl_pkg::PBL_G_GAP: begin
                n.gcnt = r.gcnt + 10'h001;
                if (r.gcnt == `PBL_GAP_BITS - 10'h001) begin
                    n.gcnt = '0;
                    n.gst = pbl_pkg::PBL_G_PKT;
                end
                if (!r.bist.gen) begin
                    n.gst = pbl_pkg::PBL_G_IDLE;
                end
            end
            pbl_pkg::PBL_G_DONE: begin
                if (!r.bist.gen) begin
                    n.gst = pbl_pkg::PBL_G_IDLE;
                end
            end
        endcase

        if (!r.strap_done) begin
            n.xmii.rgmii = STRAP_RGMII_I;
            n.xmii.rmii = STRAP_RMII_I;
            n.xmii.clksel = STRAP_CLKSEL_I;
            n.xmii.rxdly = STRAP_RXDLY_I;
            n.xmii.txdly = STRAP_TXDLY_I;
        end

        if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                `PBL_A_BIST: begin
                    n.rdata = r.bist;
                    n.rdata[11] = chk_lock;
                    n.rdata[9] = active;
                end
                `PBL_A_XMII: begin
                    n.rdata = r.xmii;
                    n.xmii.ovf_ok = 1'b1;
                    n.xmii.unf_ok = 1'b1;
                end
                `PBL_A_ERRC: n.rdata = chk_cnt;
                `PBL_A_ISTS: n.rdata = {12'h000, r.ists};
                `PBL_A_IEN:  n.rdata = {12'h000, r.ien};
                `PBL_A_LPX:  n.rdata = {15'h0000, r.mac_lp};
                default:     n.rdata = '0;
            endcase
            if (rd_bist) begin
                n.bist.loss = 1'b0;
            end
        end

        if (REG_WR_I) begin
            unique case (REG_ADDR_I)
                `PBL_A_BIST: begin
                    n.bist.cmode = bw.cmode;
                    n.bist.pktt = bw.pktt;
                    n.bist.gen = bw.gen;
                    n.bist.lptx = bw.lptx;
                    n.bist.lpsel = bw.lpsel;
                    n.bist.low = bw.low;
                end
                `PBL_A_XMII: begin
                    xw.res15 = 1'b0;
                    xw.ovf_ok = n.xmii.ovf_ok;
                    xw.unf_ok = n.xmii.unf_ok;
                    n.xmii = xw;
                end
                `PBL_A_ICLR: n.ists = r.ists & ~REG_WDATA_I[3:0];
                `PBL_A_IEN:  n.ien = REG_WDATA_I[3:0];
                `PBL_A_LPX:  n.mac_lp = REG_WDATA_I[0];
                default: begin
                end
            endcase
        end

        // Hardware events win over clears
        if (chk_loss) begin
            n.bist.loss = 1'b1;
        end
        if (RX_OVF_I) begin
            n.xmii.ovf_ok = 1'b0;
        end
        if (RX_UNF_I) begin
            n.xmii.unf_ok = 1'b0;
        end
        ev.loss = chk_loss;
        ev.wrap = chk_wrap;
        ev.ovf = RX_OVF_I;
        n.ists = n.ists | ev;

        if (n.xmii.rgmii) begin
            n.mode = pbl_pkg::PBL_RGMII;
        end else if (n.xmii.rmii) begin
            n.mode = pbl_pkg::PBL_RMII;
        end else begin
            n.mode = pbl_pkg::PBL_MII;
        end

        n.p1 = src;
        n.mrx = r.p1;
        n.crs = r.p1.en;
        if (r.mode == pbl_pkg::PBL_RMII && !r.xmii.rev10 && r.p1.en
            && !src.en) begin
            n.crs = !r.crs;
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{bist: `PBL_BIST_RST, xmii: `PBL_XMII_RST,
                   gst: pbl_pkg::PBL_G_IDLE, glfsr: `PBL_PRBS_SEED,
                   mode: pbl_pkg::PBL_MII, default: '0};
        end else begin
            r <= n;
        end
    end

    assign REG_RDATA_O = r.rdata;
    assign MAC_RX_O    = r.mrx;
    assign LINE_TX_O   = r.ltx;
    assign MODE_O      = r.mode;
    assign CRS_DV_O    = r.crs;
    assign ERR_WRAP_O  = chk_wrap;
    assign IRQ_O       = |(r.ists & r.ien);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!rst_n);

    chk_loss_sticky: assert property (
        chk_loss || r.bist.loss && !rd_bist |=> r.bist.loss)
        else $error("sync loss flag not latched");
    chk_lock_read: assert property (
        rd_bist |=> REG_RDATA_O[11] == $past(chk_lock))
        else $error("lock bit read wrong");
    chk_gen_status: assert property (
        rd_bist |=> REG_RDATA_O[9] == $past(active))
        else $error("generator status read wrong");
    chk_gen_start: assert property (
        r.bist.gen && r.gst == pbl_pkg::PBL_G_IDLE
        |=> r.gst == pbl_pkg::PBL_G_PKT ##1 LINE_TX_O.en || r.mac_lp
            || r.bist.lpsel != 4'h0)
        else $error("generator did not start");
    chk_gen_stop: assert property (
        !r.bist.gen |=> r.gst == pbl_pkg::PBL_G_IDLE
                        || r.gst == $past(r.gst) && !$past(active))
        else $error("generator still running after disable");
    chk_single_pkt: assert property (
        r.gst == pbl_pkg::PBL_G_DONE && r.bist.gen
        |=> r.gst == pbl_pkg::PBL_G_DONE && !active && !chk_lock)
        else $error("single packet mode sent more");
    chk_cont_pkts: assert property (
        r.gst == pbl_pkg::PBL_G_PKT && r.bist.gen && r.bist.pktt
        && r.gcnt == `PBL_PKT_BITS - 10'h001 |=> r.gst == pbl_pkg::PBL_G_GAP)
        else $error("continuous mode did not continue");
    chk_rev_loop: assert property (
        !r.mac_lp && r.bist.lpsel == pbl_pkg::PBL_LP_REV
        |=> LINE_TX_O == $past(LINE_RX_I))
        else $error("reverse loopback path wrong");
    chk_pcs_loop: assert property (
        !r.mac_lp && r.bist.lpsel == pbl_pkg::PBL_LP_PCS
        |=> !LINE_TX_O.en ##1 MAC_RX_O == $past(txp, 2))
        else $error("PCS loopback path wrong");
    chk_lp_tx_off: assert property (
        r.mac_lp && !r.bist.lptx |=> !LINE_TX_O.en)
        else $error("line driven in suppressed loopback");
    chk_mode_sel: assert property (
        r.strap_done |-> MODE_O == (r.xmii.rgmii ? pbl_pkg::PBL_RGMII
            : r.xmii.rmii ? pbl_pkg::PBL_RMII : pbl_pkg::PBL_MII))
        else $error("MAC interface mode wrong");
    chk_ovf_low: assert property (
        RX_OVF_I |=> !r.xmii.ovf_ok)
        else $error("overflow not recorded");
    chk_crs_rev10: assert property (
        r.xmii.rev10 |=> CRS_DV_O == $past(r.p1.en))
        else $error("CRS_DV not held to last data");

    cov_single_done: cover property (r.gst == pbl_pkg::PBL_G_DONE);
    cov_locked: cover property (chk_lock && r.gst == pbl_pkg::PBL_G_GAP);
    cov_wrap: cover property (chk_wrap);
    cov_mac_lp_tx: cover property (r.mac_lp && r.bist.lptx && LINE_TX_O.en);
endmodule // pbl_bist_ctrl

// *** pbl_cfg.svh ***
`ifndef PBL_CFG_SVH
`define PBL_CFG_SVH

// Register offsets
`define PBL_A_BIST      8'h16
`define PBL_A_XMII      8'h17
`define PBL_A_ERRC      8'h1a
`define PBL_A_ISTS      8'h1b
`define PBL_A_ICLR      8'h1c
`define PBL_A_IEN       8'h1d
`define PBL_A_LPX       8'h1e

// Reset values
`define PBL_BIST_RST    16'h0100
`define PBL_XMII_RST    16'h404d

// Generator and checker counts
`define PBL_PKT_BITS    10'd512
`define PBL_GAP_BITS    10'd96
`define PBL_CONST_BYTE  8'ha5
`define PBL_PRBS_SEED   15'h7fff
`define PBL_LOCK_RUN    5'd31
`define PBL_LOSS_RUN    3'd7
`define PBL_ERR_MAX     16'hffff

`endif

// *** pbl_pkg.sv ***
package pbl_pkg;

    typedef struct packed {
        logic en;
        logic d;
    } pbl_bit_t;

    typedef struct packed {
        logic       res15;
        logic       cmode;
        logic       pktt;
        logic       gen;
        logic       lock;
        logic       loss;
        logic       gst;
        logic [1:0] res8_7;
        logic       lptx;
        logic [3:0] lpsel;
        logic [1:0] low;
    } pbl_bist_t;

    typedef struct packed {
        logic       res15;
        logic [1:0] thr;
        logic       rxdly;
        logic       txdly;
        logic       res10;
        logic       rgmii;
        logic       res8;
        logic       clksel;
        logic       res6;
        logic       rmii;
        logic       rev10;
        logic       ovf_ok;
        logic       unf_ok;
        logic [1:0] ebuf;
    } pbl_xmii_t;

    typedef struct packed {
        logic ovf;
        logic done;
        logic wrap;
        logic loss;
    } pbl_irq_t;

    typedef enum logic [3:0] {
        PBL_LP_NONE = 4'h0,
        PBL_LP_PCS  = 4'h1,
        PBL_LP_ANA  = 4'h2,
        PBL_LP_REV  = 4'h4,
        PBL_LP_RES  = 4'h8
    } pbl_lp_t;

    typedef enum logic [1:0] {
        PBL_MII   = 2'h0,
        PBL_RMII  = 2'h1,
        PBL_RGMII = 2'h2
    } pbl_mode_t;

    typedef enum logic [1:0] {
        PBL_G_IDLE = 2'h0,
        PBL_G_PKT  = 2'h1,
        PBL_G_GAP  = 2'h3,
        PBL_G_DONE = 2'h2
    } pbl_gst_t;

    typedef struct packed {
        logic [14:0] lfsr;
        logic [4:0]  run;
        logic [2:0]  bad;
        logic        lock;
        logic        loss;
        logic        wrap;
        logic [15:0] cnt;
    } pbl_chk_st_t;

    typedef struct packed {
        pbl_bist_t   bist;
        pbl_xmii_t   xmii;
        logic        mac_lp;
        pbl_irq_t    ists;
        pbl_irq_t    ien;
        pbl_gst_t    gst;
        logic [9:0]  gcnt;
        logic [14:0] glfsr;
        pbl_bit_t    ltx;
        pbl_bit_t    p1;
        pbl_bit_t    mrx;
        logic        crs;
        pbl_mode_t   mode;
        logic [15:0] rdata;
        logic        strap_done;
    } pbl_st_t;

    // Feedback of the x^15 + x^14 + 1 sequence
    function automatic logic pbl_prbs_fb(input logic [14:0] s);
        return s[14] ^ s[13];
    endfunction

endpackage

// *** pbl_prbs_chk.sv ***
`timescale 1ns/10ps
`include "pbl_cfg.svh"

module pbl_prbs_chk (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              en_i,
    input  wire pbl_pkg::pbl_bit_t rx_i,
    input  wire logic              cmode_i,
    input  wire logic              clr_i,
    output logic                   lock_o,
    output logic                   loss_o,
    output logic                   wrap_o,
    output logic [15:0]            cnt_o
);
    pbl_pkg::pbl_chk_st_t r;
    pbl_pkg::pbl_chk_st_t n;
    logic                 miss;

    always_comb begin
        n = r;
        n.loss = 1'b0;
        n.wrap = 1'b0;
        miss = rx_i.d != pbl_pkg::pbl_prbs_fb(r.lfsr);
        if (!en_i) begin
            n.lock = 1'b0;
            n.run = '0;
            n.bad = '0;
        end else if (rx_i.en) begin
            n.lfsr = {r.lfsr[13:0], rx_i.d};
            if (!r.lock) begin
                n.run = miss ? 5'h00 : r.run + 5'h01;
                n.lock = !miss && r.run == `PBL_LOCK_RUN;
            end else if (miss) begin
                n.bad = r.bad + 3'h1;
                if (r.bad == `PBL_LOSS_RUN) begin
                    n.lock = 1'b0;
                    n.loss = 1'b1;
                    n.run = '0;
                    n.bad = '0;
                end
                if (r.cnt != `PBL_ERR_MAX) begin
                    n.cnt = r.cnt + 16'h0001;
                end else if (cmode_i) begin
                    n.cnt = '0;
                    n.wrap = 1'b1;
                end // Single mode holds at max
            end else begin
                n.bad = '0;
            end
        end
        if (clr_i) begin
            n.cnt = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '{lfsr: `PBL_PRBS_SEED, default: '0};
        end else begin
            r <= n;
        end
    end

    assign lock_o = r.lock;
    assign loss_o = r.loss;
    assign wrap_o = r.wrap;
    assign cnt_o  = r.cnt;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_err_wrap: assert property (
        wrap_o |-> cnt_o == 16'h0000 && $past(cnt_o) == `PBL_ERR_MAX)
        else $error("wrap without counter restart");
    chk_single_hold: assert property (
        !cmode_i && !clr_i && cnt_o == `PBL_ERR_MAX
        |=> cnt_o == `PBL_ERR_MAX && !wrap_o)
        else $error("single mode counter moved past max");
    chk_count_locked: assert property (
        !lock_o && !clr_i |=> cnt_o == $past(cnt_o))
        else $error("errors counted while unlocked");
endmodule // pbl_prbs_chk

// *** pbl_link_partner.sv ***
`timescale 1ns/10ps
module pbl_link_partner (
    input  wire logic              clk_i,
    input  wire logic              flip_i,
    input  wire pbl_pkg::pbl_bit_t tx_i,
    output pbl_pkg::pbl_bit_t      rx_o
);
    pbl_pkg::pbl_bit_t rx_r = '0;

    // Echo the line; flip_i corrupts bits, idle data toggles
    always_ff @(posedge clk_i) begin
        rx_r.en <= tx_i.en;
        rx_r.d  <= tx_i.en ? (tx_i.d ^ flip_i) : ~rx_r.d;
    end

    assign rx_o = rx_r;
endmodule // pbl_link_partner

// *** prbs_bist_loopback_control_tb.sv ***
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    err_count++; $display("wrong value %s exp %h got %h", nm, ex, got); \
    end end
module prbs_bist_loopback_control_tb;
    logic               clk    = 1'b0;
    logic               arst_n = 1'b0;
    logic [7:0]         addr   = '0;
    logic [15:0]        wdata  = '0;
    logic               wr     = 1'b0;
    logic               rd     = 1'b0;
    logic               ovf    = 1'b0;
    logic               unf    = 1'b0;
    logic               flip   = 1'b0;
    pbl_pkg::pbl_bit_t  mac_tx = '0;
    pbl_pkg::pbl_bit_t  mac_rx, line_tx, line_rx;
    pbl_pkg::pbl_mode_t mode;
    logic [15:0]        rdata, v;
    logic               irq, crs, wrap;
    int                 err_count = 0;
    int                 n_checks  = 0;

    pbl_bist_ctrl u_dut (.CLK_I(clk), .ARST_N_I(arst_n), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .MAC_TX_I(mac_tx), .MAC_RX_O(mac_rx),
        .LINE_TX_O(line_tx), .LINE_RX_I(line_rx), .RX_OVF_I(ovf),
        .RX_UNF_I(unf), .STRAP_RGMII_I(1'b0), .STRAP_RMII_I(1'b0),
        .STRAP_CLKSEL_I(1'b0), .STRAP_RXDLY_I(1'b0), .STRAP_TXDLY_I(1'b0),
        .MODE_O(mode), .CRS_DV_O(crs), .ERR_WRAP_O(wrap), .IRQ_O(irq));

    pbl_link_partner u_partner (.clk_i(clk), .flip_i(flip),
        .tx_i(line_tx), .rx_o(line_rx));

    initial begin
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    task automatic t_reset();
        rd_reg(8'h16);
        `CHK("bist reset", 16'h0100, v)
        rd_reg(8'h17);
        `CHK("xmii reset", 16'h404d, v)
        rd_reg(8'h30);
        `CHK("unmapped", 16'h0000, v)
        `CHK("mode reset", pbl_pkg::PBL_MII, mode)
        $display("test reset done");
    endtask

    task automatic t_mode();
        logic [15:0] w [4] = '{16'h404d, 16'h406d, 16'h424d, 16'h426d};
        pbl_pkg::pbl_mode_t m [4] = '{pbl_pkg::PBL_MII, pbl_pkg::PBL_RMII,
            pbl_pkg::PBL_RGMII, pbl_pkg::PBL_RGMII};
        for (int i = 0; i < 4; i++) begin
            wr_reg(8'h17, w[i]);
            cyc(2);
            `CHK("mode", m[i], mode)
        end
        $display("test mode done");
    endtask

    task automatic t_loop();
        logic [15:0] w [5] = '{16'h0000, 16'h0008, 16'h0010, 16'h0020,
            16'h0004};
        logic        e [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        mac_tx <= '{en: 1'b1, d: 1'b1};
        for (int i = 0; i < 5; i++) begin
            wr_reg(8'h16, w[i]);
            cyc(4);
            `CHK("line en", e[i], line_tx.en)
        end
        `CHK("pcs rx", 2'b11, mac_rx)
        wr_reg(8'h1e, 16'h0001);
        wr_reg(8'h16, 16'h0000);
        cyc(4);
        `CHK("mac lp line", 1'b0, line_tx.en)
        `CHK("mac lp rx", 2'b11, mac_rx)
        // Line transmit bit set only under MAC-side loopback
        wr_reg(8'h16, 16'h0040);
        cyc(4);
        `CHK("mac lp line", 1'b1, line_tx.en)
        wr_reg(8'h16, 16'h0000);
        wr_reg(8'h1e, 16'h0000);
        mac_tx <= '0;
        cyc(4);
        $display("test loopback done");
    endtask

    task automatic t_prbs();
        wr_reg(8'h1d, 16'h0001);
        wr_reg(8'h16, 16'h3000);
        cyc(60);
        rd_reg(8'h16);
        `CHK("locked", 16'h3b00, v)
        rd_reg(8'h1a);
        `CHK("no errors", 16'h0000, v)
        @(posedge clk);
        flip <= 1'b1;
        cyc(10);
        flip <= 1'b0;
        cyc(3);
        rd_reg(8'h16);
        `CHK("sync loss", 16'h3700, v)
        rd_reg(8'h16);
        `CHK("loss cleared", 1'b0, v[10])
        rd_reg(8'h1a);
        `CHK("errors", 16'h0008, v)
        `CHK("no wrap", 1'b0, wrap)
        `CHK("irq set", 1'b1, irq)
        wr_reg(8'h1c, 16'h0001);
        cyc(2);
        `CHK("irq clear", 1'b0, irq)
        wr_reg(8'h16, 16'h2000);
        cyc(4);
        rd_reg(8'h16);
        `CHK("gen off", 16'h2100, v & 16'hf3ff)
        $display("test prbs done");
    endtask

    task automatic t_const();
        int         n = 0;
        logic [7:0] b = '0;
        wr_reg(8'h16, 16'h1000);
        repeat (800) begin
            @(posedge clk);
            #1;
            if (line_tx.en === 1'b1) begin
                if (n < 8) b[n] = line_tx.d;
                n++;
            end
        end
        `CHK("const len", 512, n)
        `CHK("const byte", 8'ha5, b)
        rd_reg(8'h16);
        `CHK("const done", 16'h1100, v)
        $display("test constant done");
    endtask

    task automatic t_fifo();
        @(posedge clk);
        ovf <= 1'b1;
        unf <= 1'b1;
        @(posedge clk);
        ovf <= 1'b0;
        unf <= 1'b0;
        rd_reg(8'h17);
        `CHK("fifo fault", 2'b00, v[3:2])
        rd_reg(8'h17);
        `CHK("fifo normal", 2'b11, v[3:2])
        $display("test fifo done");
    endtask

    task automatic t_crs();
        int n_hi;
        int n_lo;
        wr_reg(8'h1e, 16'h0001);
        for (int i = 0; i < 2; i++) begin
            n_hi = 0;
            n_lo = 0;
            wr_reg(8'h17, i ? 16'h407d : 16'h406d);
            for (int k = 0; k < 30; k++) begin
                @(posedge clk);
                mac_tx <= '{en: k < 20, d: 1'b0};
                #1;
                if (mac_rx.en === 1'b1 && crs !== 1'b1) n_lo++;
                if (crs === 1'b1) n_hi++;
            end
            `CHK("crs high", i ? 20 : 19, n_hi)
            `CHK("crs early drop", i ? 0 : 1, n_lo)
        end
        wr_reg(8'h1e, 16'h0000);
        $display("test crs done");
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        cyc(4);
        t_reset();
        t_mode();
        t_loop();
        t_prbs();
        t_const();
        t_fifo();
        t_crs();
        test_done();
    end

    // Run needs about a thousand cycles
    initial begin
        #100000;
        err_count++;
        test_done();
    end
endmodule // prbs_bist_loopback_control_tb
